// File: hw/hbf_pkg.sv
package hbf_pkg;

  localparam int IN_W = 12;
  localparam int OUT_W = 16;
  localparam int TAPS = 55;
  localparam int CTR = 27;
  localparam int NZ = 14;
  localparam int COEF_W = 16;
  localparam int ACC_W = 36;
  localparam int FRAC_SHIFT = 11;
  localparam int LATENCY = 6;
  localparam int PAD_N = LATENCY - 3;
  localparam int FIFO_DEPTH = 16;

  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] DATA_OFS = 32'h0000_0008;

  localparam int CTRL_UPS_BIT = 0;
  localparam int CTRL_HALF_BIT = 1;
  localparam int CTRL_ROUND_LSB = 2;
  localparam int CTRL_FMT_BIT = 5;
  localparam int CTRL_CAP_BIT = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_013f;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0123;

  localparam int STAT_INTERP_BIT = 0;
  localparam int STAT_DECIM_BIT = 1;
  localparam int STAT_PHASE_BIT = 2;
  localparam int STAT_DROP_BIT = 3;
  localparam int STAT_CNT_LSB = 4;
  localparam int STAT_EMPTY_BIT = 9;
  localparam int DATA_VALID_BIT = 31;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [OUT_W-1:0] SAT_POS = 16'h7fff;
  localparam logic [OUT_W-1:0] SAT_NEG = 16'h8000;

  typedef enum logic [1:0] {
    HBF_PASS,
    HBF_INTERP,
    HBF_DECIM
  } hbf_mode_t;

  typedef struct packed {
    logic [OUT_W-1:0] word;
    logic keep;
  } hbf_stage_t;

endpackage

// File: hw/hbf_filter_top.sv
// What this block does
// - Every register updates only on the rising edge of the one clock.
// - Equal mode bits give pass-through, full rate, marker ignored.
// - Capture a 12-bit two's complement sample, bit 0 least significant.
// - Overflow saturates the result to 7fff or 8000.
// - Interpolate mode forces every other incoming sample to zero.
// - Decimate mode loads the output register on every second edge.
// - Add half-LSB below chosen LSB, zero bits below; width 16 down to 9.
// - Round code 0 puts the LSB at bit 0, each step one bit higher.
// - Result is always rounded before the output register loads.
// - Format select high gives two's complement, low inverts all but MSB.
// - Output drive low enables the pins, high floats them, unclocked.
// - Response to a sample starts 6 cycles later and ends at 60.
// - Impulse peak appears 33 cycles after the impulse enters.
// - DC gain near 1 in pass and decimate, near one quarter interpolating.
// - Output rate is half, equal or double the input rate by mode.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module hbf_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] next_count;
  logic push, pop;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];

  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module hbf_filter_top import hbf_pkg::*; #(
  parameter int FIFO_W = OUT_W,
  parameter int FIFO_D = FIFO_DEPTH,
  parameter logic [NZ*COEF_W-1:0] COEF_SIDE = '0,
  parameter logic [COEF_W-1:0] COEF_CTR = 16'h4000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [IN_W-1:0] sample_in,
  input wire logic align_marker,
  input wire logic output_drive_n,
  output logic [OUT_W-1:0] sample_out,
  output logic sample_out_oe
);
  localparam int CW = $clog2(FIFO_D) + 1;

  // Pin synchronisers
  logic [IN_W-1:0] in_s1, in_s2;
  logic mark_s1, mark_s2;

  // Front end state
  logic mark_q, data_q, next_mark_q, next_data_q, cur_data;
  logic [IN_W-1:0] dly [TAPS];
  logic [IN_W-1:0] next_dly [TAPS];
  logic kp0, next_kp0;

  // Arithmetic pipeline state
  logic signed [ACC_W-1:0] acc_q, next_acc;
  logic acc_keep, next_acc_keep;
  hbf_stage_t rounded_q, next_rounded;
  hbf_stage_t pad [PAD_N];
  hbf_stage_t next_pad [PAD_N];
  logic [OUT_W-1:0] out_q, next_out;
  logic push_q, next_push, load;

  // Register bus state
  logic [31:0] ctrl, next_ctrl;
  logic drop, next_drop;
  logic next_awready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire, rd_fire, fifo_pop;

  logic fifo_in_ready, fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [CW-1:0] fifo_count;

  hbf_mode_t mode;
  logic [2:0] round_code;
  logic fmt_twos, cap_en;

  always_comb begin
    round_code = ctrl[CTRL_ROUND_LSB +: 3];
    fmt_twos = ctrl[CTRL_FMT_BIT];
    cap_en = ctrl[CTRL_CAP_BIT];
    if (ctrl[CTRL_UPS_BIT] == ctrl[CTRL_HALF_BIT]) begin
      mode = HBF_PASS;
    end else if (!ctrl[CTRL_UPS_BIT]) begin
      mode = HBF_INTERP;
    end else begin
      mode = HBF_DECIM;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_s1 <= '0;
      in_s2 <= '0;
      mark_s1 <= 1'b0;
      mark_s2 <= 1'b0;
    end else begin
      in_s1 <= sample_in;
      in_s2 <= in_s1;
      mark_s1 <= align_marker;
      mark_s2 <= mark_s1;
    end
  end

  always_comb begin
    // a high marker forces a data phase; the first low after it is not one
    // half-rate toggling keeps the same phase
    cur_data = mark_q ? 1'b1 : ~data_q;
    next_mark_q = mark_s2;
    next_data_q = cur_data;
    // synchronised 12-bit sample enters the delay line
    // interpolate: data phase alternates from the marker
    if (mode == HBF_INTERP && !cur_data) begin
      next_dly[0] = '0;
    end else begin
      next_dly[0] = in_s2;
    end
    // marker ignored outside decimate for the output load
    next_kp0 = (mode == HBF_DECIM) ? cur_data : 1'b1;
    for (int i = 1; i < TAPS; i++) begin
      next_dly[i] = dly[i-1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mark_q <= 1'b0;
      data_q <= 1'b0;
      kp0 <= 1'b0;
      for (int i = 0; i < TAPS; i++) begin
        dly[i] <= '0;
      end
    end else begin
      mark_q <= next_mark_q;
      data_q <= next_data_q;
      kp0 <= next_kp0;
      for (int i = 0; i < TAPS; i++) begin
        dly[i] <= next_dly[i];
      end
    end
  end

  logic signed [ACC_W-1:0] sum, rsum, shv;
  logic signed [IN_W:0] pair;
  logic [OUT_W-1:0] word;
  int sh;

  always_comb begin
    // symmetric half-band, centre plus odd-offset pairs
    // gain set by the coefficient parameters
    sum = ACC_W'(signed'(dly[CTR])) * ACC_W'(signed'(COEF_CTR));
    pair = '0;
    for (int k = 0; k < NZ; k++) begin
      pair = (IN_W+1)'(signed'(dly[CTR-2*k-1]))
           + (IN_W+1)'(signed'(dly[CTR+2*k+1]));
      sum = sum + ACC_W'(pair)
          * ACC_W'(signed'(COEF_SIDE[k*COEF_W +: COEF_W]));
    end
    next_acc = sum;
    next_acc_keep = kp0;

    // Interpolated output word carries LSB weight one bit higher
    sh = (mode == HBF_INTERP) ? FRAC_SHIFT + 1 : FRAC_SHIFT;
    // half-LSB added below the effective LSB
    // effective LSB is output bit round_code
    // rounding always precedes the output register
    rsum = acc_q + (ACC_W'(1) <<< (sh + int'(round_code) - 1));
    shv = rsum >>> sh;
    if (&shv[ACC_W-1:OUT_W-1] || !(|shv[ACC_W-1:OUT_W-1])) begin
      word = shv[OUT_W-1:0] & (SAT_POS | SAT_NEG) << round_code;
    end else begin
      word = shv[ACC_W-1] ? SAT_NEG : SAT_POS;
    end
    // offset binary inverts all bits but the MSB
    if (!fmt_twos) begin
      word = {word[OUT_W-1], ~word[OUT_W-2:0]};
    end
    next_rounded.word = word;
    next_rounded.keep = acc_keep;

    // padding sets first response at 6 cycles
    // centre tap therefore lands at 33 cycles
    next_pad[0] = rounded_q;
    for (int i = 1; i < PAD_N; i++) begin
      next_pad[i] = pad[i-1];
    end
    // output rate follows the load pattern of the mode
    // decimate loads only on kept phases
    load = (mode != HBF_DECIM) | pad[PAD_N-1].keep;
    next_out = load ? pad[PAD_N-1].word : out_q;
    next_push = load & cap_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= '0;
      acc_keep <= 1'b0;
      rounded_q <= '0;
      out_q <= '0;
      push_q <= 1'b0;
      for (int i = 0; i < PAD_N; i++) begin
        pad[i] <= '0;
      end
    end else begin
      acc_q <= next_acc;
      acc_keep <= next_acc_keep;
      rounded_q <= next_rounded;
      out_q <= next_out;
      push_q <= next_push;
      for (int i = 0; i < PAD_N; i++) begin
        pad[i] <= next_pad[i];
      end
    end
  end

  // Capture keeps pushing while the FIFO is full; refused words are lost and flag drop
  hbf_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk(aclk),
    .resetn(aresetn),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(FIFO_W'(out_q)),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  always_comb begin
    wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
    rd_fire = s_axi_arready & s_axi_arvalid;
    next_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                 & ~s_axi_bvalid;
    next_arready = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    next_ctrl = ctrl;
    next_bresp = s_axi_bresp;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_drop = drop;
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (s_axi_awaddr == CTRL_OFS) begin
        for (int b = 0; b < 4; b++) begin
          if (s_axi_wstrb[b]) begin
            next_ctrl[8*b +: 8] = s_axi_wdata[8*b +: 8];
          end
        end
        next_ctrl = next_ctrl & CTRL_MASK;
      end else if (s_axi_awaddr == STAT_OFS) begin
        if (s_axi_wstrb[0] && s_axi_wdata[STAT_DROP_BIT]) begin
          next_drop = 1'b0;
        end
      end else if (s_axi_awaddr != DATA_OFS) begin
        next_bresp = RESP_SLVERR;
      end
    end
    // Set wins over a same-cycle clear
    if (push_q && !fifo_in_ready) begin
      next_drop = 1'b1;
    end

    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    fifo_pop = 1'b0;
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      if (s_axi_araddr == CTRL_OFS) begin
        next_rdata = ctrl;
      end else if (s_axi_araddr == STAT_OFS) begin
        next_rdata[STAT_INTERP_BIT] = mode == HBF_INTERP;
        next_rdata[STAT_DECIM_BIT] = mode == HBF_DECIM;
        next_rdata[STAT_PHASE_BIT] = data_q;
        next_rdata[STAT_DROP_BIT] = drop;
        next_rdata[STAT_CNT_LSB +: CW] = fifo_count;
        next_rdata[STAT_EMPTY_BIT] = ~fifo_out_valid;
      end else if (s_axi_araddr == DATA_OFS) begin
        next_rdata[DATA_VALID_BIT] = fifo_out_valid;
        next_rdata[FIFO_W-1:0] = fifo_out_valid ? fifo_out_data : '0;
        fifo_pop = fifo_out_valid;
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      drop <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      drop <= next_drop;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_awready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // enable follows the pin without a clock
  assign sample_out = out_q;
  assign sample_out_oe = ~output_drive_n;

endmodule

// File: sim/hbf_filter_properties.sv
`timescale 1ns/1ns
module hbf_filter_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic output_drive_n,
  input wire logic sample_out_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_oe_async: assert property (sample_out_oe == !output_drive_n)
    else $error("output enable does not follow drive pin");
  chk_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("write address and data ready differ");
  chk_aw_cause: assert property (s_axi_awready |->
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
    else $error("write accepted without both valids");
  chk_b_after: assert property (s_axi_awready |=>
    s_axi_bvalid && !s_axi_awready)
    else $error("write response late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_ar_wait: assert property (s_axi_arvalid && !s_axi_rvalid &&
    !s_axi_arready |-> ##[1:2] s_axi_arready)
    else $error("read address not accepted");
  chk_ar_answer: assert property (s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_float: cover property (!sample_out_oe);
endmodule

bind hbf_filter_top hbf_filter_properties u_props (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .output_drive_n, .sample_out_oe);

// File: sim/hbf_src.sv
`timescale 1ns/1ns
module hbf_src import hbf_pkg::*; (
  input wire logic aclk,
  input wire logic interp,
  input wire logic sync_req,
  input wire logic [IN_W-1:0] imp_val,
  input wire logic [IN_W-1:0] dc_val,
  output logic [IN_W-1:0] sample_in,
  output logic align_marker
);
  logic pend = 1'b0;
  logic off = 1'b0;
  initial begin
    sample_in = '0;
    align_marker = 1'b0;
  end
  always @(posedge aclk) begin
    align_marker <= sync_req;
    pend <= sync_req;
    off <= pend ? 1'b1 : ~off;
    sample_in <= pend ? imp_val : (interp && off) ? ~dc_val : dc_val;
  end
endmodule

// File: sim/hbf_filter_top_tb.sv
`timescale 1ns/1ns
module hbf_filter_top_tb import hbf_pkg::*; ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, align_marker, output_drive_n;
  logic sample_out_oe, interp, sync_req;
  logic [IN_W-1:0] sample_in, imp_val, dc_val;
  logic [OUT_W-1:0] sample_out;
  logic [OUT_W-1:0] rec [0:69];
  wire [OUT_W-1:0] out_bus = sample_out_oe ? sample_out : 'z;
  int errors = 0;
  int num_checks = 0;
  always #10 aclk = ~aclk;
  hbf_filter_top #(.COEF_SIDE({NZ{16'h1000}})) dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sample_in, .align_marker, .output_drive_n,
    .sample_out, .sample_out_oe);
  hbf_src src (.aclk, .interp, .sync_req, .imp_val, .dc_val, .sample_in,
    .align_marker);
  task print_verdict;
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tmo(input int n);
    if (n >= 50) begin
      errors++;
      $display("MISMATCH %0t bus timeout", $time);
      print_verdict;
    end
  endtask
  task axi_wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_awready; n++) @(posedge aclk);
    tmo(n);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    for (n = 0; n < 50 && !s_axi_bvalid; n++) @(posedge aclk);
    tmo(n);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task axi_rd(input logic [31:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_arready; n++) @(posedge aclk);
    tmo(n);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 50 && !s_axi_rvalid; n++) @(posedge aclk);
    tmo(n);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  function logic [31:0] exp_round(input int n, input logic tc);
    logic [15:0] m;
    m = 16'h0808;
    if (n > 0) m = (m + (16'h1 << (n - 1))) & ~((16'h1 << n) - 16'h1);
    return {16'h0, tc ? m : m ^ 16'h7fff};
  endfunction
  // Settle on a level, then mark phase and send one word
  task run_imp(input logic [31:0] c, input logic [IN_W-1:0] imp,
    input logic [IN_W-1:0] dc);
    axi_wr(CTRL_OFS, c);
    interp <= c[1] & ~c[0];
    imp_val <= imp;
    dc_val <= dc;
    repeat (70) @(posedge aclk);
    sync_req <= 1'b1;
    @(posedge aclk);
    sync_req <= 1'b0;
    // Sample mid-cycle, where the registered output has settled
    for (int i = 0; i < 70; i++) begin
      @(negedge aclk);
      rec[i] = sample_out;
    end
    @(posedge aclk);
  endtask
  task t_regs;
    axi_rd(CTRL_OFS);
    cmp(rd, CTRL_RESET);
    axi_wr(CTRL_OFS, 32'hffff_ffff);
    axi_rd(CTRL_OFS);
    cmp(rd, CTRL_MASK);
    axi_wr(32'h40, 32'h1);
    cmp(rsp, RESP_SLVERR);
    axi_rd(32'h40);
    cmp(rsp, RESP_SLVERR);
    cmp(rd, 32'h0);
  endtask
  task t_pass;
    for (int k = 0; k < 2; k++) begin
      run_imp(k ? 32'h120 : 32'h123, k ? 12'hf00 : 12'h100, 12'h0);
      cmp(rec[9], 32'h0);
      cmp(rec[10], k ? 32'hfe00 : 32'h0200);
      cmp(rec[11], 32'h0);
      cmp(rec[37], k ? 32'hf800 : 32'h0800);
      cmp(rec[64], k ? 32'hfe00 : 32'h0200);
      cmp(rec[65], 32'h0);
    end
  endtask
  task t_round;
    for (int n = 0; n < 8; n++) begin
      run_imp({23'h0, 1'b1, 2'b0, n[0], n[2:0], 2'b11}, 12'h101, 12'h0);
      cmp(rec[37], exp_round(n, n[0]));
    end
  endtask
  task t_sat;
    run_imp(32'h123, 12'h7ff, 12'h7ff);
    cmp(rec[69], {16'h0, SAT_POS});
    run_imp(32'h123, 12'h800, 12'h800);
    cmp(rec[69], {16'h0, SAT_NEG});
  endtask
  task t_decim;
    int ch;
    ch = 0;
    run_imp(32'h121, 12'h100, 12'h0);
    for (int i = 1; i < 69; i++) begin
      if (rec[i] !== rec[i-1]) begin
        ch++;
        cmp(rec[i+1], rec[i]);
      end
    end
    cmp(ch > 0, 32'h1);
  endtask
  task t_interp;
    run_imp(32'h122, 12'h010, 12'h010);
    cmp(rec[66] + rec[67], 32'd512);
    cmp(rec[66] == 16'd64 || rec[67] == 16'd64, 32'h1);
    cmp(rec[68], rec[66]);
    cmp(rec[69], rec[67]);
  endtask
  task t_oe;
    output_drive_n <= 1'b1;
    #1;
    cmp({16'h0, out_bus}, {16'h0, 16'hzzzz});
    cmp(sample_out_oe, 32'h0);
    @(posedge aclk);
    output_drive_n <= 1'b0;
    #1;
    cmp(sample_out_oe, 32'h1);
    @(posedge aclk);
  endtask
  // Capture ran long enough to overflow; drain it dry
  task t_buf;
    axi_wr(CTRL_OFS, 32'h023);
    axi_rd(STAT_OFS);
    cmp(rd & 32'h3f8, 32'h108);
    axi_wr(STAT_OFS, 32'h8);
    for (int i = 0; i < 17; i++) begin
      axi_rd(DATA_OFS);
      cmp(rd[31], i < 16);
    end
    axi_rd(STAT_OFS);
    cmp(rd & 32'h3f8, 32'h200);
  endtask
  initial begin
    s_axi_awaddr = '0;
    s_axi_wdata = '0;
    s_axi_araddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    output_drive_n = 1'b0;
    interp = 1'b0;
    sync_req = 1'b0;
    imp_val = '0;
    dc_val = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_pass;
    t_round;
    t_sat;
    t_decim;
    t_interp;
    t_oe;
    t_buf;
    print_verdict;
  end
endmodule
